// ---- core/compare_pkg.sv ----
// Purpose: constants and types for one output compare channel
// Assumes: 50 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes:   the rule summary below is held by the channel in core/
//
// Summary of operation
// - time base select bit picks timer
// - pin changes when timer equals compare
// - mode 000 disables channel, no interrupt
// - mode 001 low, match forces high, interrupt
// - mode 010 high, match forces low
// - mode 011 toggles pin, both edges interrupt
// - mode 100 single pulse, falling edge interrupt
// - mode 101 continuous pulses, falling edge interrupt
// - mode 110 PWM, fault ignored, no interrupt
// - mode 111 PWM, fault falling edge interrupts
// - fault flag set by hardware only
// - idle stop bit halts channel in idle
// - unused control bits read zero
package compare_pkg;
    // byte offsets of the registers
    localparam logic [7:0] OFF_CONTROL   = 8'h00;
    localparam logic [7:0] OFF_PRIMARY   = 8'h04;
    localparam logic [7:0] OFF_SECONDARY = 8'h08;
    localparam logic [7:0] OFF_STATUS    = 8'h0C;
    localparam logic [7:0] OFF_MASK      = 8'h10;
    // control field positions
    localparam int MODE_LSB   = 0;
    localparam int TSEL_BIT   = 3;
    localparam int FLT_BIT    = 4;
    localparam int IDLE_BIT   = 13;
    localparam logic [15:0] CTRL_WMASK = 16'h200F;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CMP_RESET  = 16'h0000;
    // status bits
    localparam int ST_PIN_EDGE = 0;
    localparam int ST_FAULT    = 1;
    localparam logic [1:0] ST_RESET = 2'h0;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_DECERR = 2'h3;

    typedef enum logic [2:0] {
        MODE_OFF    = 3'h0,
        MODE_LOW_HI = 3'h1,
        MODE_HI_LOW = 3'h2,
        MODE_TOGGLE = 3'h3,
        MODE_ONE_PULSE = 3'h4,
        MODE_CONT_PULSE = 3'h5,
        MODE_PWM    = 3'h6,
        MODE_PWM_FLT = 3'h7
    } compare_mode_e;

    // the two time bases, value plus rollover pulse
    typedef struct packed {
        logic [15:0] count;
        logic        rollover;
    } time_base_s;
endpackage

// ---- core/output_compare_channel.sv ----
// Purpose: output compare channel with AXI4-Lite registers and interrupt
// Assumes: timers and idle flag come from logic on aclk; fault pin is async
// Notes:   pin output enable is low in disabled mode, handing pin to GPIO
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module output_compare_channel
    import compare_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire time_base_s  first_time_base,
    input  wire time_base_s  second_time_base,
    input  wire logic        cpu_idle,
    input  wire logic        fault_input,
    output logic             compare_output_pin,
    output logic             compare_output_pin_oe,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [15:0]   compare_channel_control;
    logic [15:0]   primary_compare_value;
    logic [15:0]   secondary_compare_value;
    logic [1:0]    irq_status;
    logic [1:0]    irq_mask;
    logic          fault_status_flag;
    logic          fault_meta;
    logic          fault_sync;
    logic          fault_last;
    logic          pin_last;
    logic          pulse_done;
    logic          setup_pending;
    logic [7:0]    aw_addr;
    logic          aw_held;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          w_held;
    compare_mode_e mode;
    time_base_s    tb;
    logic          halted;
    logic          match_pri;
    logic          match_sec;
    logic          next_pin;
    logic          pin_event;
    logic          fault_fall;
    logic          do_write;
    logic          read_status;

    // 16-bit write merge honouring byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        merge16 = old_v;
        if (strb[0]) begin
            merge16[7:0] = data[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = data[15:8];
        end
    endfunction

    assign mode = compare_mode_e'(compare_channel_control[MODE_LSB +: 3]);
    assign tb = compare_channel_control[TSEL_BIT] ? second_time_base : first_time_base;
    assign halted = compare_channel_control[IDLE_BIT] & cpu_idle;
    assign match_pri = !halted && (tb.count == primary_compare_value);
    assign match_sec = !halted && (tb.count == secondary_compare_value);
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign read_status = s_axi_arvalid && s_axi_arready && (s_axi_araddr == OFF_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // fault pin synchroniser and falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_meta <= 1'b1;
            fault_sync <= 1'b1;
            fault_last <= 1'b1;
        end else begin
            fault_meta <= fault_input;
            fault_sync <= fault_meta;
            fault_last <= fault_sync;
        end
    end
    assign fault_fall = fault_last & ~fault_sync;

    ////////////////////////////////////////////////////////////////////////
    // next pin level per mode
    always_comb begin
        next_pin = compare_output_pin;
        if (setup_pending) begin
            unique case (mode)
                MODE_OFF:        next_pin = compare_output_pin;
                MODE_LOW_HI:     next_pin = 1'b0;
                MODE_HI_LOW:     next_pin = 1'b1;
                MODE_TOGGLE:     next_pin = compare_output_pin;
                MODE_ONE_PULSE:  next_pin = 1'b0;
                MODE_CONT_PULSE: next_pin = 1'b0;
                MODE_PWM,
                MODE_PWM_FLT:    next_pin = (primary_compare_value != CMP_RESET);
            endcase
        end else if (!halted) begin
            unique case (mode)
                MODE_OFF:        next_pin = compare_output_pin;
                MODE_LOW_HI:     next_pin = match_pri ? 1'b1 : compare_output_pin;
                MODE_HI_LOW:     next_pin = match_pri ? 1'b0 : compare_output_pin;
                MODE_TOGGLE:     next_pin = match_pri ? ~compare_output_pin : compare_output_pin;
                // rise on primary, fall on secondary, once
                MODE_ONE_PULSE: begin
                    if (match_pri && !pulse_done) begin
                        next_pin = 1'b1;
                    end else if (match_sec && compare_output_pin) begin
                        next_pin = 1'b0;
                    end
                end
                // rise on primary, fall on secondary, repeating
                MODE_CONT_PULSE: begin
                    if (match_pri) begin
                        next_pin = 1'b1;
                    end else if (match_sec) begin
                        next_pin = 1'b0;
                    end
                end
                // low at match, high at rollover unless primary is zero
                MODE_PWM,
                MODE_PWM_FLT: begin
                    if (mode == MODE_PWM_FLT && (fault_status_flag || fault_fall)) begin
                        next_pin = 1'b0; // fault holds pin inactive
                    end else if (match_pri) begin
                        next_pin = 1'b0;
                    end else if (tb.rollover) begin
                        next_pin = (primary_compare_value != CMP_RESET);
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt source selection per mode
    always_comb begin
        pin_event = 1'b0;
        unique case (mode)
            MODE_OFF:        pin_event = 1'b0;
            MODE_LOW_HI:     pin_event = ~pin_last & compare_output_pin;
            MODE_HI_LOW:     pin_event = 1'b0;
            MODE_TOGGLE:     pin_event = pin_last ^ compare_output_pin;
            MODE_ONE_PULSE,
            MODE_CONT_PULSE: pin_event = pin_last & ~compare_output_pin;
            MODE_PWM:        pin_event = 1'b0;
            MODE_PWM_FLT:    pin_event = fault_fall;
        endcase
        if (setup_pending) begin
            pin_event = 1'b0; // setup level is not an event
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin, setup and one-shot tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_output_pin    <= 1'b0;
            compare_output_pin_oe <= 1'b0;
            pin_last              <= 1'b0;
            pulse_done            <= 1'b0;
            setup_pending         <= 1'b0;
        end else begin
            compare_output_pin    <= next_pin;
            pin_last              <= setup_pending ? next_pin : compare_output_pin;
            // gpio keeps the pin when off
            compare_output_pin_oe <= (mode != MODE_OFF);
            if (do_write && aw_addr == OFF_CONTROL) begin
                setup_pending <= 1'b1;
                pulse_done    <= 1'b0;
            end else begin
                setup_pending <= 1'b0;
                if (mode == MODE_ONE_PULSE && match_pri && !halted) begin
                    pulse_done <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault flag: only hardware touches it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_status_flag <= 1'b0;
        end else if (mode == MODE_PWM_FLT) begin
            // set on fault, cleared by hardware at a rollover once the fault line is back high
            if (fault_fall) begin
                fault_status_flag <= 1'b1;
            end else if (fault_sync && tb.rollover) begin
                fault_status_flag <= 1'b0;
            end
        end else begin
            fault_status_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status: set beats clear-on-read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= ST_RESET;
            irq       <= 1'b0;
        end else begin
            irq_status[ST_PIN_EDGE] <= (irq_status[ST_PIN_EDGE] & ~read_status)
                                       | (pin_event & (mode != MODE_PWM_FLT));
            irq_status[ST_FAULT]    <= (irq_status[ST_FAULT] & ~read_status)
                                       | (pin_event & (mode == MODE_PWM_FLT));
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write channel capture, address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= AXI_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (aw_addr)
                    OFF_CONTROL, OFF_PRIMARY, OFF_SECONDARY, OFF_STATUS, OFF_MASK:
                        s_axi_bresp <= AXI_OKAY;
                    default: s_axi_bresp <= AXI_DECERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_channel_control <= CTRL_RESET;
            primary_compare_value   <= CMP_RESET;
            secondary_compare_value <= CMP_RESET;
            irq_mask                <= ST_RESET;
        end else if (do_write) begin
            unique case (aw_addr)
                // unused and fault bits not writable
                OFF_CONTROL: compare_channel_control <=
                    merge16(compare_channel_control, w_data, w_strb) & CTRL_WMASK;
                OFF_PRIMARY: primary_compare_value <=
                    merge16(primary_compare_value, w_data, w_strb);
                OFF_SECONDARY: secondary_compare_value <=
                    merge16(secondary_compare_value, w_data, w_strb);
                OFF_MASK: if (w_strb[0]) begin
                    irq_mask <= w_data[1:0];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel, answer one cycle after address taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= AXI_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                unique case (s_axi_araddr)
                    OFF_CONTROL: begin
                        s_axi_rdata[15:0]    <= compare_channel_control & CTRL_WMASK;
                        s_axi_rdata[FLT_BIT] <= fault_status_flag;
                    end
                    OFF_PRIMARY:   s_axi_rdata[15:0] <= primary_compare_value;
                    OFF_SECONDARY: s_axi_rdata[15:0] <= secondary_compare_value;
                    OFF_STATUS:    s_axi_rdata[1:0]  <= irq_status;
                    OFF_MASK:      s_axi_rdata[1:0]  <= irq_mask;
                    default:       s_axi_rresp       <= AXI_DECERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // output_compare_channel

// ---- verif/compare_pin_partner.sv ----
// Purpose: load circuit on the compare pin, plus the fault line source
// Assumes: the board pulls the pin line high when the channel releases it
// Notes:   edges are tallied on the line, not on the raw pin output
`timescale 1ns/100ps
module compare_pin_partner (
    input  wire logic       aclk,
    input  wire logic       pin,
    input  wire logic       pin_oe,
    input  wire logic       fault_req,
    input  wire logic       clear,
    output logic            fault_n,
    output logic [7:0]      rises,
    output logic [7:0]      falls
);
    logic line, line_q;
    // released pin floats to the pull-up, not to its last value
    assign line    = pin_oe ? pin : 1'b1;
    assign fault_n = !fault_req; // fault line is active low
    ////////////////////////////////////////////////////////////////////////////
    // edge tally as the load sees it
    always_ff @(posedge aclk) begin
        line_q <= line;
        if (clear) begin
            rises <= 8'h00;
            falls <= 8'h00;
        end else begin
            rises <= rises + 8'(line && !line_q);
            falls <= falls + 8'(!line && line_q);
        end
    end
endmodule // compare_pin_partner

// ---- verif/output_compare_checker.sv ----
// Purpose: port-level assertions for the output compare channel
// Assumes: control changes only through completed register writes
// Notes:   quiet counts cycles since write traffic, hiding setup edges
`timescale 1ns/100ps
module output_compare_checker
    import compare_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire time_base_s  first_time_base,
    input wire time_base_s  second_time_base,
    input wire logic        cpu_idle,
    input wire logic        compare_output_pin,
    input wire logic        compare_output_pin_oe,
    input wire logic        irq
);
    logic [15:0] ctl, pri, w_d, cnt;
    logic [7:0]  w_a;
    logic [2:0]  quiet, m;
    logic        roll, pin, done, q4, hlt;
    // selected time base and shorthand
    assign cnt  = ctl[TSEL_BIT] ? second_time_base.count : first_time_base.count;
    assign roll = ctl[TSEL_BIT] ? second_time_base.rollover : first_time_base.rollover;
    assign pin  = compare_output_pin;
    assign done = s_axi_bvalid && s_axi_bready;
    assign m    = ctl[2:0];
    assign q4   = quiet == 3'h4;
    assign hlt  = ctl[IDLE_BIT] && cpu_idle;
    // shadow of control and primary; setup edges land before quiet saturates
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) w_a <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) w_d <= s_axi_wdata[15:0];
        if (!aresetn) begin
            ctl   <= CTRL_RESET;
            pri   <= CMP_RESET;
            quiet <= 3'h0;
        end else begin
            if (done && w_a == OFF_CONTROL) ctl <= w_d & CTRL_WMASK;
            if (done && w_a == OFF_PRIMARY) pri <= w_d;
            if (s_axi_awvalid || s_axi_bvalid) quiet <= 3'h0;
            else if (!q4) quiet <= quiet + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped early");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    AST_OE_MODE: assert property (q4 |-> compare_output_pin_oe == (m != 3'h0))
        else $error("pin enable does not follow mode");
    AST_HIGH_SHOT: assert property (q4 && m == 3'h1 |-> !$fell(pin))
        else $error("pin fell in rising one-shot mode");
    AST_LOW_SHOT: assert property (q4 && m == 3'h2 |-> !$rose(pin))
        else $error("pin rose in falling one-shot mode");
    AST_TOGGLE: assert property (q4 && m == 3'h3 && $changed(pin) |-> $past(cnt) == pri)
        else $error("toggle without compare match");
    AST_PWM_LOW: assert property (q4 && m == 3'h6 && $fell(pin) |-> $past(cnt) == pri)
        else $error("pwm fell away from primary match");
    AST_PWM_HIGH: assert property (q4 && m == 3'h6 && $rose(pin) |-> $past(roll) && |pri)
        else $error("pwm rose away from rollover");
    AST_IDLE: assert property (q4 && hlt && $past(cpu_idle) |-> $stable(pin))
        else $error("pin moved while halted in idle");
    COV_IRQ: cover property ($rose(irq));
    COV_PWM: cover property (m == 3'h6 && $rose(pin));
    COV_IDLE: cover property (hlt);
endmodule // output_compare_checker

bind output_compare_channel output_compare_checker output_compare_checker_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .first_time_base, .second_time_base, .cpu_idle,
    .compare_output_pin, .compare_output_pin_oe, .irq);

// ---- verif/tb_output_compare_channel.sv ----
// Purpose: self-checking bench for the output compare channel
// Assumes: timers stop around control writes; period is 16 counts
// Notes:   compares sit at 4 and 9; each row runs 28 timer counts
`timescale 1ns/100ps
module tb_output_compare_channel
    import compare_pkg::*;
;
    logic        aclk, aresetn, awv, wv, bre, arv, rre, idle, fault, clr, run, sel, prev;
    logic        awr, wrdy, bv, arr, rv, pin, oe, irq, fault_n;
    logic [7:0]  awa, ara, rises, falls;
    logic [31:0] wd, rdat, q;
    logic [1:0]  br, rr, rs;
    logic [35:0] row;
    time_base_s  tb1, tb2;
    int          n_errors, checked;
    // idle, rises, falls, start pin (2 keeps, 3 skips), status, control
    localparam logic [35:0] ROWS [10] = '{36'h00030_0000, 36'h01001_0001, 36'h00110_000A,
        36'h01121_0003, 36'h01101_000C, 36'h02201_0005, 36'h10000_200D, 36'h12201_0005,
        36'h01210_0006, 36'h01210_000F};
    output_compare_channel output_compare_channel_inst (.aclk, .aresetn, .irq,
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .first_time_base(tb1), .second_time_base(tb2), .cpu_idle(idle),
        .fault_input(fault_n), .compare_output_pin(pin), .compare_output_pin_oe(oe));
    compare_pin_partner compare_pin_partner_inst (.aclk, .pin, .pin_oe(oe),
        .fault_req(fault), .clear(clr), .fault_n, .rises, .falls);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // only the selected base counts, so a wrong select shows no edges
    always @(posedge aclk) begin
        tb1.count    <= (run && !sel) ? (tb1.count + 16'h1) & 16'h000F : 16'h0000;
        tb1.rollover <= run && !sel && tb1.count == 16'h000F;
        tb2.count    <= (run && sel) ? (tb2.count + 16'h1) & 16'h000F : 16'h0000;
        tb2.rollover <= run && sel && tb2.count == 16'h000F;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one bus transfer; each channel drops valid once taken
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic [1:0] rsp);
        int n;
        n = 0;
        @(posedge aclk);
        if (w) begin
            awa <= a;
            wd  <= d;
            awv <= 1'b1;
            wv  <= 1'b1;
            bre <= 1'b1;
        end else begin
            ara <= a;
            arv <= 1'b1;
            rre <= 1'b1;
        end
        do begin
            @(posedge aclk);
            n++;
            if (awr === 1'b1) awv <= 1'b0;
            if (wrdy === 1'b1) wv <= 1'b0;
            if (arr === 1'b1) arv <= 1'b0;
        end while (bv !== 1'b1 && rv !== 1'b1 && n < 40);
        rd = rdat;
        rsp = w ? br : rr;
        bre <= 1'b0;
        rre <= 1'b0;
        if (n >= 40) begin
            n_errors++;
            conclude();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        {awv, wv, bre, arv, rre, idle, fault, clr, run, sel} = '0;
        {awa, ara, wd} = '0;
        n_errors = 0;
        checked = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            acc(1'b0, 8'(a * 4), 32'h0, q, rs);
            if (a < 5) chk("reset value", 32'h0, q);
            chk("read resp", 32'((a == 5) ? AXI_DECERR : AXI_OKAY), 32'(rs));
        end
        acc(1'b1, 8'h14, 32'h1, q, rs);
        chk("write resp", 32'(AXI_DECERR), 32'(rs));
        acc(1'b1, OFF_CONTROL, 32'hFFFFFFFF, q, rs);
        acc(1'b0, OFF_CONTROL, 32'h0, q, rs);
        chk("control bits", 32'h0000200F, q);
        acc(1'b1, OFF_PRIMARY, 32'h4, q, rs);
        acc(1'b1, OFF_SECONDARY, 32'h9, q, rs);
        acc(1'b1, OFF_MASK, 32'h1, q, rs);
        acc(1'b0, OFF_PRIMARY, 32'h0, q, rs);
        chk("primary", 32'h4, q);
        $display("test registers done");
        foreach (ROWS[i]) begin
            row = ROWS[i];
            prev = pin;
            sel <= row[TSEL_BIT];
            acc(1'b1, OFF_CONTROL, {16'h0000, row[15:0]}, q, rs);
            repeat (4) @(posedge aclk);
            chk("pin enable", 32'(row[2:0] != 3'h0), 32'(oe));
            if (row[23:20] != 4'h3)
                chk("start pin", 32'(row[21] ? prev : row[20]), 32'(pin));
            acc(1'b0, OFF_STATUS, 32'h0, q, rs);
            clr <= 1'b1;
            idle <= row[32];
            run <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
            repeat (27) @(posedge aclk);
            run <= 1'b0;
            idle <= 1'b0;
            repeat (3) @(posedge aclk);
            chk("rises", 32'(row[31:28]), 32'(rises));
            chk("falls", 32'(row[27:24]), 32'(falls));
            chk("irq", 32'(row[16]), 32'(irq));
            acc(1'b0, OFF_STATUS, 32'h0, q, rs);
            chk("status", 32'(row[16]), q);
            $display("test row %0d done", i);
        end
        run <= 1'b1;
        repeat (19) @(posedge aclk);
        run <= 1'b0;
        chk("pwm high", 32'h1, 32'(pin));
        fault <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("fault pin", 32'h0, 32'(pin));
        chk("fault masked", 32'h0, 32'(irq));
        acc(1'b1, OFF_CONTROL, 32'h0000000F, q, rs);
        acc(1'b0, OFF_CONTROL, 32'h0, q, rs);
        chk("fault flag", 32'h0000001F, q);
        acc(1'b1, OFF_MASK, 32'h3, q, rs);
        repeat (3) @(posedge aclk);
        chk("fault irq", 32'h1, 32'(irq));
        acc(1'b0, OFF_STATUS, 32'h0, q, rs);
        chk("fault status", 32'h2, q);
        repeat (3) @(posedge aclk);
        chk("irq cleared", 32'h0, 32'(irq));
        fault <= 1'b0;
        run <= 1'b1;
        repeat (24) @(posedge aclk);
        run <= 1'b0;
        acc(1'b0, OFF_CONTROL, 32'h0, q, rs);
        chk("flag cleared", 32'h0000000F, q);
        $display("test fault done");
        conclude();
    end
endmodule // tb_output_compare_channel
